/* verilog/tcd_channel_table.v */
// Behaviour
// - copy marker, chain, abort, completion bits per fetch that is not malformed
// - keep 14-bit last-chain pointer per entry
// - active flag mirrors channel provisioning
// - nonempty flag validates current-descriptor pointer
// - keep 14-bit current-descriptor pointer
// - byte count decrements per buffer access
// - in-progress flag while packet transmits
// - malformed descriptor sets null abort, returned next request
// - underflow set by downstream, cleared on release
// - keep host-next pointer from current descriptor
// - DMA address increments per buffer access
// - multi-chain flag validates next and last pointers
// - keep 14-bit next-chain pointer
// - two priority entries per channel 0..127
// - append new reference after last chain
// - high-priority list first, low when empty
`timescale 1ns/1ns
`include "tcd_consts.vh"
module tcd_channel_table #(
	parameter CHANNELS = 128,
	parameter CW = 7
)(
	input wire sys_clk_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	output wire irq_o,
	input wire prov_i,
	input wire [CW-1:0] prov_chan_i,
	input wire prov_active_i,
	input wire append_i,
	input wire [CW-1:0] append_chan_i,
	input wire append_pri_i,
	input wire [13:0] append_ref_i,
	output reg link_valid_o,
	output reg [13:0] link_after_o,
	input wire fetch_i,
	input wire [CW-1:0] fetch_chan_i,
	input wire fetch_pri_i,
	input wire fetch_malformed_i,
	input wire fetch_m_i,
	input wire fetch_ce_i,
	input wire fetch_abrt_i,
	input wire fetch_ioc_i,
	input wire [13:0] fetch_host_next_i,
	input wire [15:0] fetch_bytes_i,
	input wire [31:0] fetch_addr_i,
	input wire access_i,
	input wire [CW-1:0] access_chan_i,
	input wire access_pri_i,
	input wire release_i,
	input wire [CW-1:0] release_chan_i,
	input wire release_pri_i,
	input wire release_chain_end_i,
	input wire eop_i,
	input wire [CW-1:0] eop_chan_i,
	input wire eop_pri_i,
	input wire underflow_i,
	input wire [CW-1:0] underflow_chan_i,
	input wire req_i,
	input wire [CW-1:0] req_chan_i,
	output reg resp_valid_o,
	output reg resp_pri_o,
	output reg resp_empty_o,
	output reg resp_null_abort_o,
	output reg [13:0] resp_desc_o,
	output reg [31:0] resp_addr_o,
	output reg [15:0] resp_bytes_o
);
	localparam E = 2 * CHANNELS;
	localparam IW = CW + 1;

	// ==========================================
	// entry storage, two per channel
	reg m_copy [0:E-1];
	reg ce_copy [0:E-1];
	reg abrt_copy [0:E-1];
	reg interrupt_on_completion_copy [0:E-1];
	reg active [0:E-1];
	reg nonempty [0:E-1];
	reg multi_chain [0:E-1];
	reg packet_in_progress [0:E-1];
	reg null_abort_pending [0:E-1];
	reg underflow [0:E-1];
	reg [13:0] last_ptr [0:E-1];
	reg [13:0] cur_ptr [0:E-1];
	reg [13:0] host_next [0:E-1];
	reg [13:0] next_ptr [0:E-1];
	reg [15:0] remaining_byte_count [0:E-1];
	reg [31:0] dma_addr [0:E-1];

	reg enable;
	reg [IW-1:0] inspect_idx;
	reg [`TCD_EV_BITS-1:0] irq_stat;
	reg [`TCD_EV_BITS-1:0] irq_mask;
	reg [`TCD_EV_BITS-1:0] events;
	integer i;

	function [IW-1:0] entry;
		input [CW-1:0] chan;
		input pri;
		begin
			entry = {chan, pri};
		end
	endfunction

	wire [IW-1:0] ai = entry(append_chan_i, append_pri_i);
	wire [IW-1:0] fi = entry(fetch_chan_i, fetch_pri_i);
	wire [IW-1:0] xi = entry(access_chan_i, access_pri_i);
	wire [IW-1:0] ri = entry(release_chan_i, release_pri_i);
	wire [IW-1:0] ei = entry(eop_chan_i, eop_pri_i);
	wire [IW-1:0] hi_req = entry(req_chan_i, 1'b1);
	wire [IW-1:0] lo_req = entry(req_chan_i, 1'b0);
	// high list wins unless empty
	wire req_pri = nonempty[hi_req];
	wire [IW-1:0] qi = req_pri ? hi_req : lo_req;
	wire req_empty = !nonempty[qi] || !enable;
	wire req_na = enable && null_abort_pending[qi];

	// ==========================================
	// table updates; later statements win on the same entry
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			for (i = 0; i < E; i = i + 1)
			begin
				active[i] <= 1'b0;
				nonempty[i] <= 1'b0;
				multi_chain[i] <= 1'b0;
				packet_in_progress[i] <= 1'b0;
				null_abort_pending[i] <= 1'b0;
				underflow[i] <= 1'b0;
				// cleared so an answer on an empty list never carries unknowns
				cur_ptr[i] <= 14'h0000;
				remaining_byte_count[i] <= 16'h0000;
				dma_addr[i] <= 32'h0000_0000;
			end
			link_valid_o <= 1'b0;
			link_after_o <= 14'h0000;
		end
		else
		begin
			link_valid_o <= 1'b0;
			if (prov_i)
			begin
				active[entry(prov_chan_i, 1'b0)] <= prov_active_i;
				active[entry(prov_chan_i, 1'b1)] <= prov_active_i;
			end
			if (append_i)
			begin
				if (!nonempty[ai])
				begin
					cur_ptr[ai] <= append_ref_i;
					nonempty[ai] <= 1'b1;
					multi_chain[ai] <= 1'b0;
				end
				else
				begin
					// link after last chain, or after current when only one
					link_valid_o <= 1'b1;
					link_after_o <= multi_chain[ai] ? last_ptr[ai] : cur_ptr[ai];
					if (!multi_chain[ai])
						next_ptr[ai] <= append_ref_i;
					multi_chain[ai] <= 1'b1;
				end
				last_ptr[ai] <= append_ref_i;
			end
			if (fetch_i)
			begin
				if (fetch_malformed_i)
					null_abort_pending[fi] <= 1'b1;
				else
				begin
					m_copy[fi] <= fetch_m_i;
					ce_copy[fi] <= fetch_ce_i;
					abrt_copy[fi] <= fetch_abrt_i;
					interrupt_on_completion_copy[fi] <= fetch_ioc_i;
					host_next[fi] <= fetch_host_next_i;
					remaining_byte_count[fi] <= fetch_bytes_i;
					dma_addr[fi] <= fetch_addr_i;
				end
			end
			if (access_i)
			begin
				// saturate so zero keeps meaning fully read
				if (remaining_byte_count[xi] > `TCD_BYTE_STEP)
					remaining_byte_count[xi] <= remaining_byte_count[xi] - `TCD_BYTE_STEP;
				else
					remaining_byte_count[xi] <= 16'h0000;
				dma_addr[xi] <= dma_addr[xi] + `TCD_DWORD_STEP;
			end
			if (release_i)
			begin
				underflow[ri] <= 1'b0;
				if (!release_chain_end_i)
					cur_ptr[ri] <= host_next[ri];
				else if (multi_chain[ri])
				begin
					cur_ptr[ri] <= next_ptr[ri];
					// one chain left once the next head is the last head
					multi_chain[ri] <= (next_ptr[ri] != last_ptr[ri]);
				end
				else
					nonempty[ri] <= 1'b0;
			end
			if (eop_i)
				packet_in_progress[ei] <= 1'b0;
			if (req_i && !req_empty)
			begin
				if (req_na)
					null_abort_pending[qi] <= 1'b0;
				else
					packet_in_progress[qi] <= 1'b1;
			end
			// set beats a same-cycle release clear
			if (underflow_i)
			begin
				if (packet_in_progress[entry(underflow_chan_i, 1'b1)])
					underflow[entry(underflow_chan_i, 1'b1)] <= 1'b1;
				else
					underflow[entry(underflow_chan_i, 1'b0)] <= 1'b1;
			end
		end
	end

	// ==========================================
	// request answer, one cycle after req_i
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			resp_valid_o <= 1'b0;
			resp_pri_o <= 1'b0;
			resp_empty_o <= 1'b0;
			resp_null_abort_o <= 1'b0;
			resp_desc_o <= 14'h0000;
			resp_addr_o <= 32'h0000_0000;
			resp_bytes_o <= 16'h0000;
		end
		else
		begin
			resp_valid_o <= req_i;
			if (req_i)
			begin
				resp_pri_o <= req_pri;
				resp_empty_o <= req_empty;
				resp_null_abort_o <= !req_empty && req_na;
				resp_desc_o <= cur_ptr[qi];
				resp_addr_o <= dma_addr[qi];
				resp_bytes_o <= remaining_byte_count[qi];
			end
		end
	end

	// ==========================================
	// apb slave: read data captured in setup, no wait states
	wire setup = psel_i && !penable_i;
	wire wr = psel_i && penable_i && pwrite_i;
	wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `TCD_REG_IRQ_MASK);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign irq_o = |(irq_stat & irq_mask);

	wire [IW-1:0] k = inspect_idx;
	reg [31:0] rd;
	always @*
	begin
		rd = 32'h0000_0000;
		case (paddr_i)
			`TCD_REG_CTRL: rd = {31'h0, enable};
			`TCD_REG_INDEX: rd = {{(32-IW){1'b0}}, inspect_idx};
			`TCD_REG_WORD0: rd = {m_copy[k], ce_copy[k], last_ptr[k], active[k],
				nonempty[k], cur_ptr[k]};
			`TCD_REG_WORD1: rd = {remaining_byte_count[k], abrt_copy[k],
				interrupt_on_completion_copy[k], host_next[k]};
			`TCD_REG_WORD2: rd = dma_addr[k];
			`TCD_REG_WORD3: rd = {13'h0, packet_in_progress[k], null_abort_pending[k],
				underflow[k], 1'b0, multi_chain[k], next_ptr[k]};
			`TCD_REG_IRQ_STAT: rd = {29'h0, irq_stat};
			`TCD_REG_IRQ_MASK: rd = {29'h0, irq_mask};
			default: rd = 32'h0000_0000;
		endcase
	end

	always @*
	begin
		events = {`TCD_EV_BITS{1'b0}};
		events[`TCD_EV_UNDERFLOW] = underflow_i;
		events[`TCD_EV_NULL_ABORT] = fetch_i && fetch_malformed_i;
		events[`TCD_EV_EMPTY_REQ] = req_i && req_empty;
	end

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			prdata_o <= 32'h0000_0000;
			enable <= `TCD_CTRL_RESET;
			inspect_idx <= {IW{1'b0}};
			irq_stat <= {`TCD_EV_BITS{1'b0}};
			irq_mask <= `TCD_MASK_RESET;
		end
		else
		begin
			if (setup)
				prdata_o <= rd;
			if (wr && paddr_i == `TCD_REG_CTRL)
				enable <= pwdata_i[`TCD_CTRL_ENABLE];
			if (wr && paddr_i == `TCD_REG_INDEX)
				inspect_idx <= pwdata_i[IW-1:0];
			if (wr && paddr_i == `TCD_REG_IRQ_MASK)
				irq_mask <= pwdata_i[`TCD_EV_BITS-1:0];
			// a new event wins over a write-one clear
			if (wr && paddr_i == `TCD_REG_IRQ_STAT)
				irq_stat <= (irq_stat & ~pwdata_i[`TCD_EV_BITS-1:0]) | events;
			else
				irq_stat <= irq_stat | events;
		end
	end
endmodule

/* verilog/tcd_consts.vh */
`ifndef TCD_CONSTS_VH
`define TCD_CONSTS_VH
// ==========================================
// register byte offsets
`define TCD_REG_CTRL 8'h00
`define TCD_REG_INDEX 8'h04
`define TCD_REG_WORD0 8'h08
`define TCD_REG_WORD1 8'h0c
`define TCD_REG_WORD2 8'h10
`define TCD_REG_WORD3 8'h14
`define TCD_REG_IRQ_STAT 8'h18
`define TCD_REG_IRQ_MASK 8'h1c
// ==========================================
// field positions
`define TCD_CTRL_ENABLE 0
`define TCD_EV_UNDERFLOW 0
`define TCD_EV_NULL_ABORT 1
`define TCD_EV_EMPTY_REQ 2
`define TCD_EV_BITS 3
// ==========================================
// reset values and steps
`define TCD_CTRL_RESET 1'b1
`define TCD_MASK_RESET 3'h0
`define TCD_DWORD_STEP 32'h0000_0004
`define TCD_BYTE_STEP 16'h0004
`endif

/* bench/tcd_channel_table_sva.sv */
`timescale 1ns/1ns
// ==========
// port checker
module tcd_chk (
	input wire sys_clk_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire [7:0] paddr_i,
	input wire pslverr_o,
	input wire irq_o,
	input wire append_i,
	input wire link_valid_o,
	input wire req_i,
	input wire resp_valid_o,
	input wire resp_empty_o,
	input wire resp_null_abort_o,
	input wire [13:0] resp_desc_o,
	input wire [31:0] resp_addr_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_ask;
		req_i ##1 resp_valid_o;
	endsequence
	sequence s_bad;
		psel_i && penable_i && (paddr_i > 8'h1c || paddr_i[1:0] != 2'b00);
	endsequence
	a_resp_late: assert property (req_i |-> s_ask) else $error("late answer");
	a_resp_extra: assert property (!req_i |=> !resp_valid_o) else $error("stray answer");
	a_resp_hold: assert property (!req_i |=> $stable(resp_desc_o) && $stable(resp_addr_o))
		else $error("answer moved");
	a_null_full: assert property (resp_valid_o && resp_null_abort_o |-> !resp_empty_o)
		else $error("null abort on empty");
	a_link_cause: assert property (link_valid_o |-> $past(append_i)) else $error("stray link");
	a_rst_quiet: assert property ($fell(srst_i) |-> !irq_o && !resp_valid_o && !link_valid_o)
		else $error("busy after reset");
	a_addr_bad: assert property (s_bad |-> pslverr_o) else $error("no slave error");
	a_addr_good: assert property (psel_i && penable_i && !pslverr_o |-> paddr_i <= 8'h1c)
		else $error("error missing");
endmodule
bind tcd_channel_table tcd_chk chk (.sys_clk_i, .srst_i, .psel_i, .penable_i, .paddr_i,
	.pslverr_o, .irq_o, .append_i, .link_valid_o, .req_i, .resp_valid_o, .resp_empty_o,
	.resp_null_abort_o, .resp_desc_o, .resp_addr_o);

/* bench/tcd_dn_model.sv */
`timescale 1ns/1ns
// ==========
// downstream frame processor: data requests and underflow reports
module tcd_dn_model (
	input wire sys_clk_i,
	output reg req_o,
	output reg [6:0] chan_o,
	output reg unf_o
);
	initial {req_o, chan_o, unf_o} = 9'h000;
	// channel is inverted when idle so a stale number never looks valid
	task ask(input [6:0] c);
	begin
		@(posedge sys_clk_i);
		req_o <= 1'b1;
		chan_o <= c;
		@(posedge sys_clk_i);
		req_o <= 1'b0;
		chan_o <= ~c;
	end
	endtask
	task unf(input [6:0] c);
	begin
		@(posedge sys_clk_i);
		unf_o <= 1'b1;
		chan_o <= c;
		@(posedge sys_clk_i);
		unf_o <= 1'b0;
		chan_o <= ~c;
	end
	endtask
endmodule

/* bench/tcd_channel_table_tb.sv */
`timescale 1ns/1ns
// ==========
// bench top
module tcd_channel_table_tb;
	reg sys_clk_i = 1'b0;
	reg srst_i = 1'b1;
	reg psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pr = 1'b0, mal = 1'b0, serr;
	reg pa = 1'b1, ced = 1'b0;
	reg [7:0] paddr_i = 8'h00;
	reg [31:0] pwdata_i = 32'h0, fa = 32'h0, q;
	reg [5:0] stb = 6'h00;
	reg [6:0] ch = 7'h00;
	reg [3:0] cp = 4'h0;
	reg [13:0] rf = 14'h0, hn = 14'h0;
	reg [15:0] nb = 16'h0;
	reg [39:0] rows [0:4];
	wire [31:0] prdata_o, resp_addr_o;
	wire pready_o, pslverr_o, irq_o, link_valid_o, resp_valid_o, resp_pri_o, req, unf;
	wire resp_empty_o, resp_null_abort_o;
	wire [13:0] link_after_o, resp_desc_o;
	wire [15:0] resp_bytes_o;
	wire [6:0] dch;
	integer err_total = 0, n_checks = 0, cyc = 0, i;
	always #10 sys_clk_i = ~sys_clk_i;
	tcd_dn_model dn (.sys_clk_i, .req_o(req), .chan_o(dch), .unf_o(unf));
	tcd_channel_table uut (.sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .prov_i(stb[0]), .prov_chan_i(ch),
		.prov_active_i(pa), .append_i(stb[1]), .append_chan_i(ch), .append_pri_i(pr),
		.append_ref_i(rf), .link_valid_o, .link_after_o, .fetch_i(stb[2]), .fetch_chan_i(ch),
		.fetch_pri_i(pr), .fetch_malformed_i(mal), .fetch_m_i(cp[3]), .fetch_ce_i(cp[2]),
		.fetch_abrt_i(cp[1]), .fetch_ioc_i(cp[0]), .fetch_host_next_i(hn), .fetch_bytes_i(nb),
		.fetch_addr_i(fa), .access_i(stb[3]), .access_chan_i(ch), .access_pri_i(pr),
		.release_i(stb[4]), .release_chan_i(ch), .release_pri_i(pr), .release_chain_end_i(ced),
		.eop_i(stb[5]), .eop_chan_i(ch), .eop_pri_i(pr), .underflow_i(unf),
		.underflow_chan_i(dch), .req_i(req), .req_chan_i(dch), .resp_valid_o, .resp_pri_o,
		.resp_empty_o, .resp_null_abort_o, .resp_desc_o, .resp_addr_o, .resp_bytes_o);
	task chk(input [31:0] s, input [31:0] e);
	begin
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			err_total = err_total + 1;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	end
	endtask
	task rw(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_o !== 1'b1)
			@(posedge sys_clk_i);
		q = prdata_o;
		serr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	end
	endtask
	task op(input integer k);
	begin
		@(posedge sys_clk_i);
		stb[k] <= 1'b1;
		@(posedge sys_clk_i);
		stb <= 6'h00;
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// the whole run needs well under 1000 cycles
	always @(posedge sys_clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			err_total = err_total + 1;
			give_verdict;
		end
	end
	initial
	begin
		rows[0] = {8'h00, 32'h1};
		rows[1] = {8'h04, 32'h0};
		rows[2] = {8'h18, 32'h0};
		rows[3] = {8'h1c, 32'h0};
		rows[4] = {8'h20, 32'h0};
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		for (i = 0; i < 5; i = i + 1)
		begin
			rw(1'b0, rows[i][39:32], 32'h0);
			chk(q, rows[i][31:0]);
		end
		chk(serr, 1'b1);
		rw(1'b1, 8'h04, 32'd11);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_c000, 32'h0);
		$display("test reset done");
		ch <= 7'd5;
		pr <= 1'b1;
		rf <= 14'h0123;
		op(0);
		op(1);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_c123);
		rf <= 14'h0200;
		op(1);
		#1 chk({link_after_o, link_valid_o}, {14'h0123, 1'b1});
		rw(1'b0, 8'h14, 32'h0);
		chk(q & 32'h0000_7fff, 32'h0000_4200);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h3fff_0000, 32'h0200_0000);
		$display("test chain done");
		cp <= 4'hb;
		hn <= 14'h0055;
		nb <= 16'h0008;
		fa <= 32'h0000_1000;
		op(2);
		op(3);
		op(3);
		rw(1'b0, 8'h08, 32'h0);
		chk(q[31:30], 2'b10);
		rw(1'b0, 8'h0c, 32'h0);
		chk(q, 32'h0000_c055);
		rw(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0000_1008);
		dn.ask(7'd5);
		#1 chk({resp_valid_o, resp_pri_o, resp_empty_o, resp_null_abort_o}, 4'hc);
		chk({resp_desc_o, resp_addr_o}, {14'h0123, 32'h0000_1008});
		chk(resp_bytes_o, 16'h0000);
		rw(1'b0, 8'h14, 32'h0);
		chk(q[18:16], 3'b100);
		$display("test fetch done");
		dn.unf(7'd5);
		rw(1'b0, 8'h14, 32'h0);
		chk({q[16], irq_o}, 2'b10);
		rw(1'b1, 8'h1c, 32'h1);
		#1 chk(irq_o, 1'b1);
		rw(1'b1, 8'h18, 32'h1);
		#1 chk(irq_o, 1'b0);
		op(4);
		op(5);
		rw(1'b0, 8'h14, 32'h0);
		chk(q[18:16], 3'b000);
		ced <= 1'b1;
		op(4);
		rw(1'b0, 8'h14, 32'h0);
		chk(q & 32'h0000_4000, 32'h0);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_c200);
		op(4);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_4000, 32'h0);
		ced <= 1'b0;
		pa <= 1'b0;
		op(0);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_8000, 32'h0);
		$display("test underflow done");
		ch <= 7'd9;
		pr <= 1'b0;
		rf <= 14'h0011;
		mal <= 1'b1;
		op(1);
		op(2);
		rw(1'b1, 8'h04, 32'd18);
		rw(1'b0, 8'h14, 32'h0);
		chk(q[17], 1'b1);
		dn.ask(7'd9);
		#1 chk({resp_valid_o, resp_pri_o, resp_empty_o, resp_null_abort_o}, 4'h9);
		dn.ask(7'd9);
		#1 chk({resp_valid_o, resp_pri_o, resp_empty_o, resp_null_abort_o}, 4'h8);
		dn.ask(7'd20);
		#1 chk({resp_valid_o, resp_pri_o, resp_empty_o}, 3'b101);
		rw(1'b1, 8'h22, 32'hffff_ffff);
		chk(serr, 1'b1);
		$display("test null abort done");
		// second reset in mid-run: entry 18 holds in-progress and a list
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rw(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		rw(1'b1, 8'h04, 32'd18);
		rw(1'b0, 8'h14, 32'h0);
		chk(q & 32'h0007_4000, 32'h0);
		rw(1'b0, 8'h08, 32'h0);
		chk(q & 32'h0000_c000, 32'h0);
		$display("test mid reset done");
		give_verdict;
	end
endmodule
